// [design/cpmact_top.sv]
// Top of the copper attachment: lanes, clock source select, role and timers.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
// Behaviour
// - Reset state entered at power-up and on management or control requests.
// - Each pair continuously sends its assigned quinary symbol.
// - All four pair transmitters step on one shared symbol strobe.
// - Master role takes symbol timing from a local free-running divider.
// - Slave role takes symbol timing from recovered receive timing.
// - Receive signals sliced into one quinary symbol per pair.
// - Each receive lane uses the recovery strobe of its own index, even when the crossed pinout feeds it the other pair's samples.
// - Role value is driven continuously to the coding sublayer.
// - With crossover, a link-detected flag is kept true or false.
// - With crossover, a state holds straight or crossed pinout.
// - Transmit mode selector is held and passed to the coding sublayer.
// - Crossover toggle timer period is 1.3 s within 25 percent.
// - Training limit 750 ms as master, 350 ms as slave.
// - Short hold timer expires 1 us after start.
// - Link probe period timer runs at 62 ms.
// - Settle delay timer expires 1 us after start.
module cpmact_top
   import cpmact_pkg::*;
#(
   parameter int SAMPLE_W = 8,
   parameter int SYM_DIV = 8,
   parameter int unsigned XOVER_CYC_P = XOVER_CYC,
   parameter int unsigned TRAIN_MASTER_P = TRAIN_MASTER_CYC,
   parameter int unsigned TRAIN_SLAVE_P = TRAIN_SLAVE_CYC,
   parameter int unsigned PROBE_CYC_P = PROBE_CYC
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Reset request from the control function.
   input wire logic ctl_reset_req_i,
   // Transmit symbols, 3 bits per pair, pair a in the low bits.
   input wire logic [4*SYM_W-1:0] tx_symbols_i,
   // Received samples, pair a in the low bits.
   input wire logic [4*SAMPLE_W-1:0] rx_samples_i,
   // Recovered per-line symbol timing strobes.
   input wire logic [3:0] rx_recovered_i,
   // Signal energy seen on the line, for link detection.
   input wire logic line_energy_i,
   output logic [SYM_W-1:0] pair_a_line_o,
   output logic [SYM_W-1:0] pair_b_line_o,
   output logic [SYM_W-1:0] pair_c_line_o,
   output logic [SYM_W-1:0] pair_d_line_o,
   output logic transmit_symbol_clock_o,
   output logic [4*SYM_W-1:0] receive_symbol_primitive_o,
   output logic receive_symbol_valid_o,
   output logic config_indication_primitive_o,
   output logic [1:0] tx_mode_o,
   output logic crossed_pinout_o,
   output logic pma_reset_o
);

   localparam int TW = 32;

   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic ack_r;
   logic [31:0] dat_r;
   cpmact_state_t state_r;
   logic [$clog2(SYM_DIV)-1:0] div_r;
   logic sym_ce_r;
   logic link_det_r;
   logic crossover_state_r;
   logic [3:0] rx_ce_r;
   logic rx_valid_r;
   logic mode_r;
   logic [1:0] txmode_r;
   logic reset_r;
   logic [4*SYM_W-1:0] tx_line;
   logic [4*SYM_W-1:0] rx_sym;
   logic train_run, train_done, hold_run, hold_done;
   logic settle_run, settle_done, xover_done, probe_done;
   logic [31:0] status;

   // Bus decode: classic single cycle, ack one cycle after the request.
   wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
   wire wr_ctrl = bus_req && wb_we_i && (wb_adr_i == REG_CTRL);
   wire pma_rst = rst_i || ctl_reset_req_i || ctrl_r[CTRL_RESET_BIT];
   wire role_master = ctrl_r[CTRL_ROLE_BIT];
   wire autox = ctrl_r[CTRL_AUTOX_BIT];
   wire start_train = wr_ctrl && wb_sel_i[1] && wb_dat_i[CTRL_TRAIN_BIT];
   wire start_hold = wr_ctrl && wb_sel_i[1] && wb_dat_i[CTRL_HOLD_BIT];
   wire start_settle = wr_ctrl && wb_sel_i[1] && wb_dat_i[CTRL_SETTLE_BIT];
   wire div_wrap = (div_r == ($clog2(SYM_DIV))'(SYM_DIV - 1));
   // Slave follows pair a recovered timing; master uses the local divider.
   wire sym_tick = role_master ? div_wrap : rx_recovered_i[0];
   wire [TW-1:0] train_term = role_master ? TW'(TRAIN_MASTER_P)
                                          : TW'(TRAIN_SLAVE_P);

   // Byte-lane merge of a control write; start bits are self-clearing.
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      for (int b = 0; b < 4; b++)
      begin
         if (wb_sel_i[b])
            ctrl_nxt[8*b +: 8] = wb_dat_i[8*b +: 8];
      end
      ctrl_nxt[CTRL_SETTLE_BIT:CTRL_TRAIN_BIT] = 3'b000;
   end

   // Status word shows live role, crossover and timer state.
   assign status = {25'h0, reset_r, settle_run, hold_run, train_run,
                    crossover_state_r, link_det_r, role_master};

   // Control register and bus answer; unmapped reads return zero.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= CTRL_RESET_VAL;
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= bus_req;
         if (wr_ctrl)
            ctrl_r <= ctrl_nxt;
         if (bus_req)
         begin
            case (wb_adr_i)
               REG_CTRL: dat_r <= ctrl_r;
               REG_STATUS: dat_r <= status;
               REG_TIMER: dat_r <= {29'h0, settle_done, hold_done,
                                    train_done};
               default: dat_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Reset sequencing: remain in reset while any source asks for it.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_r <= CPMA_RST;
      else
      begin
         case (state_r)
            CPMA_RST: if (!pma_rst) state_r <= CPMA_RUN;
            CPMA_RUN: if (pma_rst) state_r <= CPMA_RST;
            default: state_r <= CPMA_RST;
         endcase
      end
   end

   wire in_reset = (state_r == CPMA_RST) || pma_rst;

   // Symbol clock: one strobe drives the transmit registers of all four lanes together; each lane gets its own receive strobe.
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         div_r <= '0;
         sym_ce_r <= 1'b0;
         rx_ce_r <= 4'h0;
         rx_valid_r <= 1'b0;
         mode_r <= 1'b0;
         txmode_r <= 2'b00;
         reset_r <= 1'b1;
      end
      else
      begin
         div_r <= div_wrap ? '0 : div_r + 1'b1;
         sym_ce_r <= sym_tick;
         rx_ce_r <= rx_recovered_i;
         rx_valid_r <= rx_ce_r[0];
         mode_r <= role_master;
         txmode_r <= ctrl_r[CTRL_TXMODE_LSB +: 2];
         reset_r <= 1'b0;
      end
   end

   // Crossover: flag link, and swap pinout on each toggle timer period while no link is detected.
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         link_det_r <= 1'b0;
         crossover_state_r <= 1'b0;
      end
      else if (autox)
      begin
         if (probe_done)
            link_det_r <= line_energy_i;
         if (xover_done && !link_det_r)
            crossover_state_r <= !crossover_state_r;
      end
   end

   // Four lanes; the crossed pinout swaps the receive samples of a with b and c with d.
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         wire [1:0] pin = crossover_state_r ? 2'(g ^ 1) : 2'(g);
         cpmact_lane #(.SAMPLE_W(SAMPLE_W)) u_lane (
            .clk_i(clk_i),
            .rst_i(in_reset),
            .tx_ce_i(sym_ce_r),
            .tx_sym_i(tx_symbols_i[g*SYM_W +: SYM_W]),
            .rx_ce_i(rx_ce_r[g]),
            .rx_sample_i(rx_samples_i[pin*SAMPLE_W +: SAMPLE_W]),
            .tx_line_o(tx_line[g*SYM_W +: SYM_W]),
            .rx_sym_o(rx_sym[g*SYM_W +: SYM_W])
         );
      end
   endgenerate

   // Control timers, each a counter of the system clock.
   cpmact_timer #(.W(TW)) u_train (
      .clk_i(clk_i), .rst_i(in_reset), .start_i(start_train),
      .periodic_i(1'b0), .term_i(train_term),
      .running_o(train_run), .done_o(train_done));
   cpmact_timer #(.W(TW)) u_hold (
      .clk_i(clk_i), .rst_i(in_reset), .start_i(start_hold),
      .periodic_i(1'b0), .term_i(TW'(HOLD_CYC)),
      .running_o(hold_run), .done_o(hold_done));
   cpmact_timer #(.W(TW)) u_settle (
      .clk_i(clk_i), .rst_i(in_reset), .start_i(start_settle),
      .periodic_i(1'b0), .term_i(TW'(SETTLE_CYC)),
      .running_o(settle_run), .done_o(settle_done));
   cpmact_timer #(.W(TW)) u_xover (
      .clk_i(clk_i), .rst_i(in_reset || !autox), .start_i(1'b0),
      .periodic_i(1'b1), .term_i(TW'(XOVER_CYC_P)),
      .running_o(), .done_o(xover_done));
   cpmact_timer #(.W(TW)) u_probe (
      .clk_i(clk_i), .rst_i(in_reset || !autox), .start_i(1'b0),
      .periodic_i(1'b1), .term_i(TW'(PROBE_CYC_P)),
      .running_o(), .done_o(probe_done));

   // Outputs, all taken from flip-flops.
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign pair_a_line_o = tx_line[0 +: SYM_W];
   assign pair_b_line_o = tx_line[SYM_W +: SYM_W];
   assign pair_c_line_o = tx_line[2*SYM_W +: SYM_W];
   assign pair_d_line_o = tx_line[3*SYM_W +: SYM_W];
   assign transmit_symbol_clock_o = sym_ce_r;
   assign receive_symbol_primitive_o = rx_sym;
   assign receive_symbol_valid_o = rx_valid_r;
   assign config_indication_primitive_o = mode_r;
   assign tx_mode_o = txmode_r;
   assign crossed_pinout_o = crossover_state_r;
   assign pma_reset_o = reset_r;

endmodule : cpmact_top

// [design/cpmact_pkg.sv]
// Package of constants shared by the copper attachment control and timer block.
package cpmact_pkg;

   // Clock rate of the single system clock in kHz.
   localparam int unsigned CLK_KHZ = 100000;

   // Timer nominal values, in their printed units.
   localparam int unsigned XOVER_PERIOD_MS = 1300;
   localparam int unsigned TRAIN_MASTER_MS = 750;
   localparam int unsigned TRAIN_SLAVE_MS = 350;
   localparam int unsigned HOLD_NS = 1000;
   localparam int unsigned PROBE_PERIOD_MS = 62;
   localparam int unsigned SETTLE_NS = 1000;

   // Cycle counts derived from the rate.
   localparam int unsigned XOVER_CYC = XOVER_PERIOD_MS * (CLK_KHZ);
   localparam int unsigned TRAIN_MASTER_CYC = TRAIN_MASTER_MS * CLK_KHZ;
   localparam int unsigned TRAIN_SLAVE_CYC = TRAIN_SLAVE_MS * CLK_KHZ;
   localparam int unsigned HOLD_CYC = HOLD_NS * CLK_KHZ / 1000000;
   localparam int unsigned PROBE_CYC = PROBE_PERIOD_MS * CLK_KHZ;
   localparam int unsigned SETTLE_CYC = SETTLE_NS * CLK_KHZ / 1000000;

   // Register byte offsets.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TIMER = 8'h08;

   // Control register field positions.
   localparam int CTRL_RESET_BIT = 0;
   localparam int CTRL_ROLE_BIT = 1;
   localparam int CTRL_AUTOX_BIT = 2;
   localparam int CTRL_TXMODE_LSB = 4;
   localparam int CTRL_TRAIN_BIT = 8;
   localparam int CTRL_HOLD_BIT = 9;
   localparam int CTRL_SETTLE_BIT = 10;
   localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

   // Status field positions.
   localparam int ST_ROLE_BIT = 0;
   localparam int ST_LINKDET_BIT = 1;
   localparam int ST_XOVER_BIT = 2;
   localparam int ST_TRAIN_BIT = 3;
   localparam int ST_HOLD_BIT = 4;
   localparam int ST_SETTLE_BIT = 5;
   localparam int ST_RESET_BIT = 6;

   // Quinary symbol code: three bits carrying -2..+2 in two's complement.
   localparam int SYM_W = 3;

   // Reset sequencing states.
   typedef enum logic [1:0]
   {
      CPMA_RST = 2'b01,
      CPMA_RUN = 2'b10
   } cpmact_state_t;

endpackage : cpmact_pkg

// [design/cpmact_timer.sv]
// One-shot or periodic cycle counter used for every control timer.
`timescale 1ns/100ps
module cpmact_timer
   import cpmact_pkg::*;
#(
   parameter int W = 28
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic periodic_i,
   input wire logic [W-1:0] term_i,
   output logic running_o,
   output logic done_o
);

   logic [W-1:0] cnt_r;
   logic run_r;
   logic done_r;
   wire hit = run_r && (cnt_r >= term_i - W'(1));

   // A start restarts the count; periodic timers reload and pulse each period.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_r <= '0;
         run_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= hit;
         // Periodic timers have no start strobe, so they arm themselves.
         if (start_i || (periodic_i && !run_r))
         begin
            cnt_r <= '0;
            run_r <= 1'b1;
         end
         else if (hit)
         begin
            cnt_r <= '0;
            run_r <= periodic_i;
         end
         else if (run_r)
            cnt_r <= cnt_r + W'(1);
      end
   end

   assign running_o = run_r;
   assign done_o = done_r;

endmodule : cpmact_timer

// [design/cpmact_lane.sv]
// Per-pair symbol lane: transmit launch register and receive slicer.
`timescale 1ns/100ps
module cpmact_lane
   import cpmact_pkg::*;
#(
   parameter int SAMPLE_W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tx_ce_i,
   input wire logic [SYM_W-1:0] tx_sym_i,
   input wire logic rx_ce_i,
   input wire logic signed [SAMPLE_W-1:0] rx_sample_i,
   output logic [SYM_W-1:0] tx_line_o,
   output logic [SYM_W-1:0] rx_sym_o
);

   localparam logic signed [SAMPLE_W-1:0] HI = SAMPLE_W'(3 <<< (SAMPLE_W-4));
   localparam logic signed [SAMPLE_W-1:0] LO = SAMPLE_W'(1 <<< (SAMPLE_W-4));

   logic [SYM_W-1:0] tx_r;
   logic [SYM_W-1:0] rx_r;
   logic [SYM_W-1:0] slice;

   // Slice the sample into one of five levels; thresholds sit between levels.
   always_comb
   begin
      if (rx_sample_i >= HI)
         slice = 3'b010;
      else if (rx_sample_i >= LO)
         slice = 3'b001;
      else if (rx_sample_i > -LO)
         slice = 3'b000;
      else if (rx_sample_i > -HI)
         slice = 3'b111;
      else
         slice = 3'b110;
   end

   // Both registers only move on their strobe, so every lane's transmit register steps together.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_r <= '0;
         rx_r <= '0;
      end
      else
      begin
         if (tx_ce_i)
            tx_r <= tx_sym_i;
         if (rx_ce_i)
            rx_r <= slice;
      end
   end

   assign tx_line_o = tx_r;
   assign rx_sym_o = rx_r;

endmodule : cpmact_lane

// [bench/cpmact_asserts.sv]
// Port-level assertions for the copper attachment top.
`timescale 1ns/100ps
module cpmact_asserts
   import cpmact_pkg::*;
#(
   parameter int unsigned XOVER_CYC_P = 200
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic ctl_reset_req_i,
   input wire logic [4*SYM_W-1:0] tx_symbols_i,
   input wire logic [3:0] rx_recovered_i,
   input wire logic [SYM_W-1:0] pair_a_line_o,
   input wire logic [SYM_W-1:0] pair_b_line_o,
   input wire logic [SYM_W-1:0] pair_c_line_o,
   input wire logic [SYM_W-1:0] pair_d_line_o,
   input wire logic transmit_symbol_clock_o,
   input wire logic config_indication_primitive_o,
   input wire logic [1:0] tx_mode_o,
   input wire logic crossed_pinout_o,
   input wire logic pma_reset_o
);
   localparam int X_LO = XOVER_CYC_P * 3 / 4;
   logic xo_r;
   logic [31:0] gap_r;
   wire tsc = transmit_symbol_clock_o;
   wire cfg = config_indication_primitive_o;
   wire [4*SYM_W-1:0] lines = {pair_d_line_o, pair_c_line_o,
      pair_b_line_o, pair_a_line_o};
   // A control write that does not also ask for a soft reset.
   wire ctrl_wr = wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL &&
      wb_sel_i[0] && !wb_dat_i[CTRL_RESET_BIT];
   wire [31:0] gap_nxt = (rst_i || pma_reset_o ||
      crossed_pinout_o != xo_r) ? 32'h0 : gap_r + 32'h1;
   // Cycles since the last pinout change, restarted by any reset.
   always_ff @(posedge clk_i)
   begin
      xo_r <= crossed_pinout_o;
      gap_r <= gap_nxt;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || pma_reset_o);
   // The master divider is checked at its default of eight cycles.
   property p_master_period;
      tsc && cfg ##1 (cfg && !tsc) [*7] ##1 cfg |-> tsc;
   endproperty
   a_master_period: assert property (p_master_period)
      else $error("master strobe period wrong");
   property p_slave_follow;
      !cfg && rx_recovered_i[0] ##1 !cfg |-> tsc;
   endproperty
   a_slave_follow: assert property (p_slave_follow)
      else $error("slave strobe missing");
   property p_slave_src;
      !cfg && $past(!cfg, 2) && tsc |-> $past(rx_recovered_i[0]);
   endproperty
   a_slave_src: assert property (p_slave_src)
      else $error("slave strobe without recovered timing");
   property p_lockstep;
      !$stable(lines) |-> $past(tsc);
   endproperty
   a_lockstep: assert property (p_lockstep)
      else $error("pair line moved off the strobe");
   property p_launch;
      tsc |=> lines == $past(tx_symbols_i);
   endproperty
   a_launch: assert property (p_launch)
      else $error("launched symbols differ");
   property p_role;
      ctrl_wr |-> ##2 cfg == $past(wb_dat_i[CTRL_ROLE_BIT], 2);
   endproperty
   a_role: assert property (p_role)
      else $error("role indication wrong");
   property p_mode;
      ctrl_wr |-> ##2 tx_mode_o == $past(wb_dat_i[CTRL_TXMODE_LSB +: 2], 2);
   endproperty
   a_mode: assert property (p_mode)
      else $error("transmit mode wrong");
   property p_reset_req;
      disable iff (rst_i) ctl_reset_req_i [*3] |-> pma_reset_o;
   endproperty
   a_reset_req: assert property (p_reset_req)
      else $error("reset request ignored");
   property p_xover_gap;
      $changed(crossed_pinout_o) |-> gap_r >= X_LO;
   endproperty
   a_xover_gap: assert property (p_xover_gap)
      else $error("pinout toggled too soon");
   c_master: cover property (tsc && cfg);
   c_slave: cover property (tsc && !cfg);
   c_toggle: cover property ($changed(crossed_pinout_o));
endmodule : cpmact_asserts

bind cpmact_top cpmact_asserts #(.XOVER_CYC_P(XOVER_CYC_P)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .ctl_reset_req_i(ctl_reset_req_i), .tx_symbols_i(tx_symbols_i),
   .rx_recovered_i(rx_recovered_i), .pair_a_line_o(pair_a_line_o),
   .pair_b_line_o(pair_b_line_o), .pair_c_line_o(pair_c_line_o),
   .pair_d_line_o(pair_d_line_o), .tx_mode_o(tx_mode_o),
   .transmit_symbol_clock_o(transmit_symbol_clock_o),
   .config_indication_primitive_o(config_indication_primitive_o),
   .crossed_pinout_o(crossed_pinout_o), .pma_reset_o(pma_reset_o));

// [bench/cpmact_remote.sv]
// Remote partner model: recovered strobes, line samples, signal energy.
`timescale 1ns/100ps
module cpmact_remote
(
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic [4:0] per_i,
   output logic [31:0] rx_samples_o,
   output logic [3:0] rx_recovered_o,
   output logic line_energy_o
);
   localparam logic [7:0] LVL[3] = '{8'h81, 8'h00, 8'h7f};
   localparam logic [2:0] SYM[3] = '{3'h6, 3'h0, 3'h2};
   logic [11:0] exp_q[$];
   logic [11:0] e;
   logic [4:0] cnt_r = 5'h00;
   logic [7:0] junk_r = 8'h5a;
   int k = 0;
   initial {rx_samples_o, rx_recovered_o, line_energy_o} = 37'h0;
   // Extreme levels slice to -2, 0 or +2 at any threshold scale; outside
   // the sampling window the lines carry changing junk, never old data;
   // a stop waits one idle cycle so a pending sample is still taken.
   always @(posedge clk_i)
   begin
      cnt_r <= (!run_i || cnt_r == per_i - 5'h01) ? 5'h00 : cnt_r + 5'h01;
      junk_r <= ~junk_r + 8'h13;
      rx_recovered_o <= {4{run_i && cnt_r == 5'h02}};
      line_energy_o <= run_i;
      if (run_i && cnt_r == 5'h02)
         exp_q.push_back(e);
      if (run_i && cnt_r == 5'h01)
      begin
         for (int p = 0; p < 4; p++)
         begin
            rx_samples_o[8*p +: 8] <= LVL[(k + p) % 3];
            e[3*p +: 3] = SYM[(k + p) % 3];
         end
         k++;
      end
      else if ((!run_i && cnt_r == 5'h00) || cnt_r == 5'h05)
         rx_samples_o <= {4{junk_r}};
   end
endmodule : cpmact_remote

// [bench/testbench.sv]
// Self-checking bench for the copper attachment control and timer block.
`timescale 1ns/100ps
module testbench;
   import cpmact_pkg::*;
   localparam int XP = 200;
   localparam int TM = 150;
   localparam int TS = 70;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, ctl_reset_req_i = 1'b0, run = 1'b0, x;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, rd, ctl = 32'h0, rx_s;
   logic [11:0] tx_symbols_i = 12'h000;
   logic [4:0] per = 5'h06;
   logic [15:0] lfsr_r = 16'h6104;
   logic [63:0] rq[$];
   logic [63:0] e;
   int n_errors = 0, n_tests = 0, cyc = 0, ph = 0, t0;
   wire [31:0] wb_dat_o;
   wire [11:0] rsym;
   wire [3:0] rx_rec;
   wire wb_ack_o, tsc, rvalid, crossed, energy;

   cpmact_remote remote (.clk_i(clk_i), .run_i(run), .per_i(per),
      .rx_samples_o(rx_s), .rx_recovered_o(rx_rec), .line_energy_o(energy));
   cpmact_top #(.XOVER_CYC_P(XP), .TRAIN_MASTER_P(TM), .TRAIN_SLAVE_P(TS),
      .PROBE_CYC_P(30)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_symbols_i(tx_symbols_i),
      .ctl_reset_req_i(ctl_reset_req_i), .rx_samples_i(rx_s),
      .rx_recovered_i(rx_rec), .line_energy_i(energy),
      .pair_a_line_o(), .pair_b_line_o(), .pair_c_line_o(), .pair_d_line_o(),
      .transmit_symbol_clock_o(tsc), .receive_symbol_primitive_o(rsym),
      .receive_symbol_valid_o(rvalid), .config_indication_primitive_o(),
      .tx_mode_o(), .crossed_pinout_o(crossed), .pma_reset_o());

   function automatic logic [15:0] lfsr_f(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_f

   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic results();
      if (n_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   // One classic cycle; a read leaves its mask and expected value queued.
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d, input logic [63:0] x);
      if (!we)
         rq.push_back(x);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      wb_sel_i <= 4'hf;
      do
         @(posedge clk_i);
      while (!wb_ack_o);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb

   // Start a timer, then poll its running flag until it falls.
   task automatic tmr(input int sb, input int rb, input int p);
      int t;
      wb(1'b1, REG_CTRL, ctl | (32'h1 << sb), 64'h0);
      t = cyc;
      wb(1'b0, REG_CTRL, 32'h0, {32'h700, 32'h0});
      do
         wb(1'b0, REG_STATUS, 32'h0, 64'h0);
      while (rd[rb] && cyc - t < 2 * p);
      chk("timer", 32'(cyc - t >= p - p / 50 && cyc - t <= p + p / 50 + 6),
         32'h1);
   endtask : tmr

   initial
   begin
      forever #5 clk_i = ~clk_i;
   end

   // Cycle count and hang limit; fresh symbols three cycles after a strobe.
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      ph <= tsc ? 1 : ph + 1;
      if (ph == 3)
      begin
         lfsr_r <= lfsr_f(lfsr_r);
         for (int p = 0; p < 4; p++)
            tx_symbols_i[3*p +: 3] <= 3'(int'(lfsr_r[4*p +: 4] % 5) - 2);
      end
      if (cyc == 12000)
      begin
         n_errors++;
         results();
      end
   end

   // Read answers and received symbols are matched to the oldest note.
   // A crossed pinout swaps pairs a with b and c with d on receive.
   always @(posedge clk_i)
   begin
      if (wb_ack_o && !wb_we_i && rq.size() > 0)
      begin
         e = rq.pop_front();
         if (e[63:32] != 32'h0)
            chk("read", wb_dat_o & e[63:32], e[31:0]);
      end
      if (rvalid)
      begin
         e[11:0] = remote.exp_q.pop_front();
         if (crossed)
            e[11:0] = {e[8:6], e[11:9], e[2:0], e[5:3]};
         chk("rx", {20'h0, rsym}, {20'h0, e[11:0]});
      end
   end

   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_CTRL, 32'h0, {32'hffffffff, CTRL_RESET_VAL});
      wb(1'b0, REG_STATUS, 32'h0, {32'h7f, 32'h0});
      wb(1'b0, REG_TIMER, 32'h0, {32'h7, 32'h0});
      wb(1'b1, 8'h0c, 32'hffffffff, 64'h0);
      wb(1'b0, 8'h0c, 32'h0, {32'hffffffff, 32'h0});
      // Every transmit mode as master, read back.
      for (int m = 0; m < 4; m++)
      begin
         ctl = 32'h2 | (m << 4);
         wb(1'b1, REG_CTRL, ctl, 64'h0);
         wb(1'b0, REG_CTRL, 32'h0, {32'h7ff, ctl});
      end
      wb(1'b0, REG_STATUS, 32'h0, {32'h1, 32'h1});
      repeat (200) @(posedge clk_i);
      // Slave: timing and data from a prompt, then a slow partner.
      ctl = 32'h0;
      wb(1'b1, REG_CTRL, ctl, 64'h0);
      for (int i = 0; i < 2; i++)
      begin
         per <= i ? 5'h0d : 5'h06;
         run <= 1'b1;
         repeat (150) @(posedge clk_i);
      end
      run <= 1'b0;
      repeat (20) @(posedge clk_i);
      wb(1'b0, REG_STATUS, 32'h0, {32'h1, 32'h0});
      tmr(CTRL_TRAIN_BIT, ST_TRAIN_BIT, TS);
      ctl = 32'h2;
      wb(1'b1, REG_CTRL, ctl, 64'h0);
      tmr(CTRL_TRAIN_BIT, ST_TRAIN_BIT, TM);
      tmr(CTRL_HOLD_BIT, ST_HOLD_BIT, HOLD_CYC);
      tmr(CTRL_SETTLE_BIT, ST_SETTLE_BIT, SETTLE_CYC);
      // Pinout search on a silent line, then hold once energy appears.
      ctl = 32'h6;
      wb(1'b1, REG_CTRL, ctl, 64'h0);
      for (int i = 0; i < 3; i++)
      begin
         t0 = cyc;
         x = crossed;
         wait (crossed !== x || cyc - t0 > 2 * XP);
         if (i > 0)
            chk("xgap", 32'(cyc - t0 >= XP * 3 / 4 && cyc - t0 <= XP * 5 / 4),
               32'h1);
      end
      run <= 1'b1;
      repeat (100) @(posedge clk_i);
      x = crossed;
      wb(1'b0, REG_STATUS, 32'h0, {32'h2, 32'h2});
      repeat (3 * XP) @(posedge clk_i);
      chk("xhold", {31'h0, crossed}, {31'h0, x});
      run <= 1'b0;
      repeat (20) @(posedge clk_i);
      // Reset request mid-timer, then a soft reset; registers survive.
      wb(1'b1, REG_CTRL, ctl | 32'h100, 64'h0);
      ctl_reset_req_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      wb(1'b0, REG_STATUS, 32'h0, {32'h40, 32'h40});
      ctl_reset_req_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      wb(1'b0, REG_CTRL, 32'h0, {32'hff, ctl});
      wb(1'b0, REG_STATUS, 32'h0, {32'h48, 32'h0});
      wb(1'b1, REG_CTRL, ctl | 32'h1, 64'h0);
      wb(1'b0, REG_STATUS, 32'h0, {32'h40, 32'h40});
      wb(1'b1, REG_CTRL, ctl, 64'h0);
      wb(1'b0, REG_STATUS, 32'h0, {32'h41, 32'h1});
      results();
   end
endmodule : testbench
